// File: core/logger_ctrl.sv
// Operation
// - Power-up lands in stand-by: log empty, clock stopped, bus still answers.
// - Idle runs the clock with an empty log, awaiting start.
// - Start comes from a reader command or the button sequence.
// - Active wakes every interval, samples, optionally stores the sample.
// - End of logging enters sleep; log held until reset command.
// - Sampling interval programmable from one second to eighteen hours.
// - Log holds at most 3958 samples, then storing stops.
// - Sixteen temperature bins, each with its own threshold alarm.
// - Button enable clear: status check only; set: start and stop too.
// - Press shorter than two seconds is a status check.
// - Battery good, no alarm: green steady for two seconds.
// - Battery good, alarm: red steady for two seconds.
// - Status alarm is OR of log_memory_full_flag, arrival, bin, kinetic, shelf flags.
// - Battery low: blink green or red by alarm for two seconds.
// - LEDs show ready with both lit, started and stopped states with alert colour.
// - Start needs long hold, release, confirming press within five seconds.
// - Accepted button start blinks slowly, green or red by alarm, and starts acquisition.
// - Button stop only when stop-disable bit is zero.
// - Stop needs long hold, release, confirming press within five seconds.
// - Accepted button stop lights green or red steady by alarm and ends acquisition.
// - Enabled bin alarms when counter reaches threshold; all ones disables.
`timescale 1ns/1ps
module logger_ctrl
  import logger_pkg::*;
#(
  parameter int unsigned QTR_CLKS = QTR_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Button pin and LEDs
  input  wire logic        button_pin,
  output logic             led_green,
  output logic             led_red,
  // Sensor and log memory side
  output logic             sample_req,
  input  wire logic        sample_valid,
  input  wire logic [3:0]  sample_bin,
  output logic             log_write,
  output logic      [11:0] log_addr,
  // Alarm and battery flags from neighbouring logic
  input  wire logic        arrival_time_alarm_flag,
  input  wire logic        kinetic_temperature_alarm_flag,
  input  wire logic        shelf_life_alarm_flag,
  input  wire logic        battery_low,
  // State view
  output logic      [1:0]  op_state
);

  typedef struct packed {
    op_state_e         st;
    ui_state_e         ui;
    logic [31:0]       qdiv;
    logic [1:0]        secq;
    logic [2:0]        blink;
    logic [4:0]        qcnt;
    logic              ui_stop;
    logic              show_alarm;
    logic              show_blink;
    logic [16:0]       interval;
    logic [16:0]       intv_cnt;
    logic              be;
    logic              sd;
    logic              store_en;
    logic [15:0]       bin_en;
    logic [15:0][15:0] thr;
    logic [15:0][15:0] cnt;
    logic [11:0]       samples;
    logic [11:0]       log_addr;
    logic [31:0]       rtc;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              led_g;
    logic              led_r;
    logic              sample_req;
    logic              log_write;
    logic              btn_meta;
    logic              btn;
  } state_s;

  state_s      s_r;
  state_s      s_nxt;
  logic        qtick;
  logic        stick;
  logic        setup_acc;
  logic        wr_done;
  logic        mapped;
  logic [11:0] addr;
  logic [3:0]  bidx;
  logic [15:0] bin_alarm;
  logic        log_memory_full_flag;
  logic        any_alarm;
  logic        cmd_clock;
  logic        cmd_start;
  logic        cmd_stop;
  logic        cmd_reset;
  logic [16:0] wr_intv;
  logic        colour_red;

  always_comb begin
    s_nxt      = s_r;
    qtick      = (s_r.qdiv == QTR_CLKS - 1);
    stick      = qtick && (s_r.secq == 2'(QTR_PER_S - 1));
    addr       = {paddr[11:2], 2'b00};
    bidx       = paddr[5:2];
    setup_acc  = psel && penable && !s_r.pready;
    wr_done    = psel && penable && s_r.pready && pwrite;
    mapped     = 1'b0;
    cmd_clock  = 1'b0;
    cmd_start  = 1'b0;
    cmd_stop   = 1'b0;
    cmd_reset  = 1'b0;
    wr_intv    = pwdata[16:0];
    colour_red = 1'b0;
    log_memory_full_flag    = (s_r.samples >= 12'(LOG_DEPTH));
    for (int i = 0; i < NUM_BINS; i++) begin
      bin_alarm[i] = s_r.bin_en[i] && (s_r.thr[i] != THR_OFF)
                     && (s_r.cnt[i] >= s_r.thr[i]);
    end
    any_alarm = log_memory_full_flag || (|bin_alarm) || arrival_time_alarm_flag
                || kinetic_temperature_alarm_flag || shelf_life_alarm_flag;

    s_nxt.sample_req = 1'b0;
    s_nxt.log_write  = 1'b0;
    s_nxt.pready     = 1'b0;
    s_nxt.pslverr    = 1'b0;
    s_nxt.btn_meta   = button_pin;
    s_nxt.btn        = s_r.btn_meta;

    // Quarter-second and second enables
    s_nxt.qdiv = qtick ? 32'h0000_0000 : s_r.qdiv + 32'h0000_0001;
    if (qtick) begin
      s_nxt.secq  = s_r.secq + 2'h1;
      s_nxt.blink = s_r.blink + 3'h1;
    end
    if (stick && s_r.st != ST_STANDBY) begin
      s_nxt.rtc = s_r.rtc + 32'h0000_0001;
    end

    // Periodic wake-up while logging
    if (s_r.st == ST_ACTIVE && stick) begin
      if (s_r.intv_cnt + 17'h1 >= s_r.interval) begin
        s_nxt.intv_cnt   = 17'h0;
        s_nxt.sample_req = 1'b1;
      end else begin
        s_nxt.intv_cnt = s_r.intv_cnt + 17'h1;
      end
    end
    if (s_r.st == ST_ACTIVE && sample_valid) begin
      if (s_r.bin_en[sample_bin] && s_r.cnt[sample_bin] != 16'hFFFF) begin
        s_nxt.cnt[sample_bin] = s_r.cnt[sample_bin] + 16'h1;
      end
      if (s_r.store_en && !log_memory_full_flag) begin
        s_nxt.log_write = 1'b1;
        s_nxt.log_addr  = s_r.samples;
        s_nxt.samples   = s_r.samples + 12'h1;
      end
    end

    // APB: one wait state, read data captured in the first access cycle
    if (setup_acc) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = 32'h0000_0000;
      mapped = 1'b1;
      if ((addr & BIN_WIN_MASK) == OFF_THR_BASE) begin
        s_nxt.prdata[15:0] = s_r.thr[bidx];
      end else if ((addr & BIN_WIN_MASK) == OFF_CNT_BASE) begin
        s_nxt.prdata[15:0] = s_r.cnt[bidx];
      end else begin
        unique case (addr)
          OFF_CTRL: begin
            s_nxt.prdata[CTRL_BE]    = s_r.be;
            s_nxt.prdata[CTRL_SD]    = s_r.sd;
            s_nxt.prdata[CTRL_STORE] = s_r.store_en;
          end
          OFF_INTERVAL:  s_nxt.prdata[16:0] = s_r.interval;
          OFF_CMD:       s_nxt.prdata = 32'h0000_0000;
          OFF_STATUS: begin
            s_nxt.prdata[1:0]         = s_r.st;
            s_nxt.prdata[STS_LOG_MEMORY_FULL_FLAG] = log_memory_full_flag;
            s_nxt.prdata[STS_BIN]     = |bin_alarm;
            s_nxt.prdata[STS_ETA]     = arrival_time_alarm_flag;
            s_nxt.prdata[STS_MKT]     = kinetic_temperature_alarm_flag;
            s_nxt.prdata[STS_SHELF]   = shelf_life_alarm_flag;
            s_nxt.prdata[STS_BATT]    = battery_low;
          end
          OFF_SAMPLES:   s_nxt.prdata[11:0] = s_r.samples;
          OFF_RTC:       s_nxt.prdata = s_r.rtc;
          OFF_BIN_EN:    s_nxt.prdata[15:0] = s_r.bin_en;
          OFF_BIN_ALARM: s_nxt.prdata[15:0] = bin_alarm;
          default:       mapped = 1'b0;
        endcase
      end
      s_nxt.pslverr = !mapped;
    end
    if (wr_done) begin
      if ((addr & BIN_WIN_MASK) == OFF_THR_BASE) begin
        s_nxt.thr[bidx] = pwdata[15:0];
      end else begin
        unique case (addr)
          OFF_CTRL: begin
            s_nxt.be       = pwdata[CTRL_BE];
            s_nxt.sd       = pwdata[CTRL_SD];
            s_nxt.store_en = pwdata[CTRL_STORE];
          end
          OFF_INTERVAL: begin
            // Out-of-range writes clamp rather than fault
            if (pwdata > 32'(INTERVAL_MAX_S)) begin
              s_nxt.interval = 17'(INTERVAL_MAX_S);
            end else if (wr_intv < 17'(INTERVAL_MIN_S)) begin
              s_nxt.interval = 17'(INTERVAL_MIN_S);
            end else begin
              s_nxt.interval = wr_intv;
            end
          end
          OFF_CMD: begin
            cmd_clock = pwdata[CMD_CLOCK];
            cmd_start = pwdata[CMD_START];
            cmd_stop  = pwdata[CMD_STOP];
            cmd_reset = pwdata[CMD_RESET];
          end
          OFF_BIN_EN: s_nxt.bin_en = pwdata[15:0];
          default: ;
        endcase
      end
    end

    // Button sequencer, timed in quarter seconds
    unique case (s_r.ui)
      UI_IDLE: begin
        if (s_r.btn) begin
          s_nxt.ui   = UI_PRESS;
          s_nxt.qcnt = 5'h0;
        end
      end
      UI_PRESS: begin
        if (!s_r.btn) begin
          if (s_r.qcnt < 5'(SHORT_Q)) begin
            s_nxt.ui         = UI_SHOW;
            s_nxt.qcnt       = 5'h0;
            s_nxt.show_alarm = any_alarm;
            s_nxt.show_blink = battery_low;
          end else begin
            s_nxt.ui = UI_IDLE;
          end
        end else if (qtick && s_r.qcnt < 5'(SHORT_Q)) begin
          s_nxt.qcnt = s_r.qcnt + 5'h1;
          if (s_r.qcnt == 5'(SHORT_Q - 1)) begin
            if (s_r.be && (s_r.st == ST_STANDBY || s_r.st == ST_IDLE)) begin
              s_nxt.ui      = UI_HELD;
              s_nxt.ui_stop = 1'b0;
            end else if (s_r.be && !s_r.sd && s_r.st == ST_ACTIVE) begin
              s_nxt.ui      = UI_HELD;
              s_nxt.ui_stop = 1'b1;
            end
          end
        end
      end
      UI_HELD: begin
        if (!s_r.btn) begin
          s_nxt.ui   = UI_CONFIRM;
          s_nxt.qcnt = 5'h0;
        end
      end
      UI_CONFIRM: begin
        if (s_r.btn) begin
          s_nxt.ui  = UI_RELEASE;
          cmd_start = cmd_start || !s_r.ui_stop;
          cmd_stop  = cmd_stop || s_r.ui_stop;
        end else if (qtick) begin
          s_nxt.qcnt = s_r.qcnt + 5'h1;
          if (s_r.qcnt == 5'(CONFIRM_Q - 1)) begin
            s_nxt.ui = UI_IDLE;
          end
        end
      end
      UI_RELEASE: begin
        // Confirming press must end before a new press is timed
        if (!s_r.btn) begin
          s_nxt.ui = UI_IDLE;
        end
      end
      UI_SHOW: begin
        if (qtick) begin
          s_nxt.qcnt = s_r.qcnt + 5'h1;
          if (s_r.qcnt == 5'(IND_Q - 1)) begin
            s_nxt.ui = UI_IDLE;
          end
        end
      end
      default: s_nxt.ui = UI_IDLE;
    endcase

    // Operating state; reset command wins over everything
    if (cmd_reset) begin
      s_nxt.st       = ST_STANDBY;
      s_nxt.samples  = 12'h0;
      s_nxt.cnt      = '0;
      s_nxt.rtc      = 32'h0000_0000;
      s_nxt.intv_cnt = 17'h0;
      s_nxt.log_write  = 1'b0;
      s_nxt.sample_req = 1'b0;
    end else begin
      unique case (s_r.st)
        ST_STANDBY: begin
          if (cmd_start) begin
            s_nxt.st       = ST_ACTIVE;
            s_nxt.intv_cnt = 17'h0;
          end else if (cmd_clock) begin
            s_nxt.st = ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (cmd_start) begin
            s_nxt.st       = ST_ACTIVE;
            s_nxt.intv_cnt = 17'h0;
          end
        end
        ST_ACTIVE: begin
          if (cmd_stop || log_memory_full_flag) begin
            s_nxt.st = ST_SLEEP;
          end
        end
        ST_SLEEP: ;
      endcase
    end

    // LED driver
    if (s_r.ui == UI_SHOW) begin
      colour_red = s_r.show_alarm;
      s_nxt.led_g = !colour_red && (!s_r.show_blink || s_r.blink[0]);
      s_nxt.led_r = colour_red && (!s_r.show_blink || s_r.blink[0]);
    end else if (s_r.ui == UI_HELD || s_r.ui == UI_CONFIRM) begin
      s_nxt.led_g = !s_r.ui_stop && s_r.blink[0];
      s_nxt.led_r = s_r.ui_stop && s_r.blink[0];
    end else begin
      unique case (s_r.st)
        ST_STANDBY, ST_IDLE: begin
          s_nxt.led_g = 1'b1;
          s_nxt.led_r = 1'b1;
        end
        ST_ACTIVE: begin
          s_nxt.led_g = !any_alarm && s_r.blink[2];
          s_nxt.led_r = any_alarm && s_r.blink[2];
        end
        ST_SLEEP: begin
          s_nxt.led_g = !any_alarm;
          s_nxt.led_r = any_alarm;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r          <= '0;
      s_r.thr      <= '1;
      s_r.interval <= 17'(INTERVAL_MIN_S);
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata     = s_r.prdata;
  assign pready     = s_r.pready;
  assign pslverr    = s_r.pslverr;
  assign led_green  = s_r.led_g;
  assign led_red    = s_r.led_r;
  assign sample_req = s_r.sample_req;
  assign log_write  = s_r.log_write;
  assign log_addr   = s_r.log_addr;
  assign op_state   = s_r.st;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_standby_empty: assert property (
    s_r.st == ST_STANDBY |-> s_r.samples == 12'h0 && s_r.rtc == 32'h0000_0000)
    else $error("stand-by with non-empty log or running clock");
  chk_idle_quiet: assert property (
    s_r.st == ST_IDLE |=> !s_r.sample_req && !s_r.log_write)
    else $error("sampling while idle");
  chk_reader_start: assert property (
    wr_done && addr == OFF_CMD && pwdata[CMD_START] && !pwdata[CMD_RESET]
    && s_r.st == ST_IDLE |=> s_r.st == ST_ACTIVE)
    else $error("reader start not accepted");
  chk_sleep_hold: assert property (
    s_r.st == ST_SLEEP |=> (s_r.st == ST_SLEEP && $stable(s_r.samples))
                           || s_r.st == ST_STANDBY)
    else $error("log changed in sleep");
  chk_interval_range: assert property (
    s_r.interval >= 17'(INTERVAL_MIN_S) && s_r.interval <= 17'(INTERVAL_MAX_S))
    else $error("interval out of range");
  chk_log_bound: assert property (
    s_r.log_write |-> s_r.log_addr < 12'(LOG_DEPTH) && $past(s_r.st) == ST_ACTIVE)
    else $error("log write beyond capacity");
  chk_green_status: assert property (
    s_r.ui == UI_SHOW && !s_r.show_alarm && !s_r.show_blink ##1 s_r.ui == UI_SHOW
    |-> led_green && !led_red)
    else $error("green status indication wrong");
  chk_red_status: assert property (
    s_r.ui == UI_SHOW && s_r.show_alarm && !s_r.show_blink ##1 s_r.ui == UI_SHOW
    |-> led_red && !led_green)
    else $error("red status indication wrong");
  chk_button_gate: assert property (
    s_r.ui == UI_PRESS && !s_r.be |=> s_r.ui != UI_HELD)
    else $error("long press armed with button disabled");
  chk_stop_gate: assert property (
    s_r.ui == UI_PRESS && s_r.sd && s_r.st == ST_ACTIVE |=> s_r.ui != UI_HELD)
    else $error("stop armed while stop disabled");
  chk_confirm_timeout: assert property (
    s_r.ui == UI_CONFIRM && qtick && s_r.qcnt == 5'(CONFIRM_Q - 1) && !s_r.btn
    && !wr_done |=> s_r.ui == UI_IDLE && $stable(s_r.st))
    else $error("confirm window did not expire cleanly");

  cov_button_start: cover property (
    s_r.ui == UI_CONFIRM && s_r.btn && !s_r.ui_stop ##1 s_r.st == ST_ACTIVE);
  cov_status_show: cover property (s_r.ui == UI_PRESS ##1 s_r.ui == UI_SHOW);
  cov_enter_sleep: cover property (s_r.st == ST_ACTIVE ##1 s_r.st == ST_SLEEP);
endmodule

// File: shared/logger_pkg.sv
package logger_pkg;
  // Timing
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned QTR_PER_S    = 4;
  localparam int unsigned QTR_CYCLES   = CLK_HZ / QTR_PER_S;
  localparam int unsigned SHORT_PRESS_S = 2;
  localparam int unsigned INDICATION_S  = 2;
  localparam int unsigned CONFIRM_S     = 5;
  localparam int unsigned SHORT_Q   = SHORT_PRESS_S * QTR_PER_S;
  localparam int unsigned IND_Q     = INDICATION_S * QTR_PER_S;
  localparam int unsigned CONFIRM_Q = CONFIRM_S * QTR_PER_S;
  localparam int unsigned INTERVAL_MIN_S = 1;
  localparam int unsigned INTERVAL_MAX_S = 18 * 3600;
  // Log and bins
  localparam int unsigned LOG_DEPTH = 3958;
  localparam int unsigned NUM_BINS  = 16;
  localparam logic [15:0] THR_OFF   = 16'hFFFF;
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_INTERVAL  = 12'h004;
  localparam logic [11:0] OFF_CMD       = 12'h008;
  localparam logic [11:0] OFF_STATUS    = 12'h00C;
  localparam logic [11:0] OFF_SAMPLES   = 12'h010;
  localparam logic [11:0] OFF_RTC       = 12'h014;
  localparam logic [11:0] OFF_BIN_EN    = 12'h018;
  localparam logic [11:0] OFF_BIN_ALARM = 12'h01C;
  localparam logic [11:0] OFF_THR_BASE  = 12'h040;
  localparam logic [11:0] OFF_CNT_BASE  = 12'h080;
  localparam logic [11:0] BIN_WIN_MASK  = 12'hFC0;
  // CTRL bits
  localparam int unsigned CTRL_BE    = 0;
  localparam int unsigned CTRL_SD    = 1;
  localparam int unsigned CTRL_STORE = 2;
  // CMD bits (write-only)
  localparam int unsigned CMD_CLOCK = 0;
  localparam int unsigned CMD_START = 1;
  localparam int unsigned CMD_STOP  = 2;
  localparam int unsigned CMD_RESET = 3;
  // STATUS bits
  localparam int unsigned STS_LOG_MEMORY_FULL_FLAG = 2;
  localparam int unsigned STS_BIN     = 3;
  localparam int unsigned STS_ETA     = 4;
  localparam int unsigned STS_MKT     = 5;
  localparam int unsigned STS_SHELF   = 6;
  localparam int unsigned STS_BATT    = 7;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_IDLE    = 2'b01,
    ST_ACTIVE  = 2'b10,
    ST_SLEEP   = 2'b11
  } op_state_e;

  typedef enum logic [2:0] {
    UI_IDLE    = 3'b000,
    UI_PRESS   = 3'b001,
    UI_HELD    = 3'b010,
    UI_CONFIRM = 3'b011,
    UI_RELEASE = 3'b100,
    UI_SHOW    = 3'b101
  } ui_state_e;
endpackage

// File: verification/logger_ctrl_test.sv
`timescale 1ns/1ps
module logger_ctrl_test;
  import logger_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        button_pin;
  logic        led_green;
  logic        led_red;
  logic        sample_req;
  logic        sample_valid;
  logic [3:0]  sample_bin;
  logic        log_write;
  logic [11:0] log_addr;
  logic        arrival_time_alarm_flag;
  logic        kinetic_temperature_alarm_flag;
  logic        shelf_life_alarm_flag;
  logic        battery_low;
  logic [1:0]  op_state;
  logic        slow;
  logic [3:0]  bin_in;
  logic [31:0] rd;
  logic        err;
  int          g;
  int          r;
  int          mismatches;
  int          n_checks;
  int          cycles;

  logger_ctrl #(.QTR_CLKS(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .button_pin(button_pin), .led_green(led_green), .led_red(led_red),
    .sample_req(sample_req), .sample_valid(sample_valid), .sample_bin(sample_bin),
    .log_write(log_write), .log_addr(log_addr),
    .arrival_time_alarm_flag(arrival_time_alarm_flag),
    .kinetic_temperature_alarm_flag(kinetic_temperature_alarm_flag),
    .shelf_life_alarm_flag(shelf_life_alarm_flag), .battery_low(battery_low),
    .op_state(op_state));

  sensor_model sensor_u (
    .pclk(pclk), .presetn(presetn), .sample_req(sample_req), .slow(slow),
    .bin_in(bin_in), .sample_valid(sample_valid), .sample_bin(sample_bin));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Run takes about 1400 cycles; ceiling leaves ample margin
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    check("pready", 1'b1, pready);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Button held for q quarter seconds of four cycles each
  task automatic press(input int q);
    button_pin <= 1'b1;
    tick(q * 4);
    button_pin <= 1'b0;
  endtask

  task automatic watch(input int n);
    g = 0;
    r = 0;
    repeat (n) begin
      @(posedge pclk);
      g += (led_green === 1'b1);
      r += (led_red === 1'b1);
    end
  endtask

  task automatic long_hold(input bit confirm);
    press(12);
    tick(12);
    if (confirm) press(4);
    else tick(100);
    tick(40);
  endtask

  task automatic t_reset_state;
    check("op_state", 2'h0, op_state);
    check("leds", 2'h3, {led_green, led_red});
    apb(1'b0, OFF_THR_BASE, 32'h0000_0000);
    check("thr0", 32'h0000_FFFF, rd);
    apb(1'b0, 12'h3F0, 32'h0000_0000);
    check("slverr", 1'b1, err);
    apb(1'b1, OFF_INTERVAL, 32'h0000_0000);
    apb(1'b0, OFF_INTERVAL, 32'h0000_0000);
    check("interval_min", INTERVAL_MIN_S, rd);
    apb(1'b1, OFF_INTERVAL, 32'h0001_0000);
    apb(1'b0, OFF_INTERVAL, 32'h0000_0000);
    check("interval_max", INTERVAL_MAX_S, rd);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    check("status_state", 32'h0000_0000, rd & 32'h0000_0003);
    tick(32);
    apb(1'b0, OFF_RTC, 32'h0000_0000);
    check("rtc_stopped", 32'h0000_0000, rd);
  endtask

  task automatic t_status;
    logic [2:0] fl [4];
    fl = '{3'h0, 3'h4, 3'h2, 3'h1};
    for (int i = 0; i < 6; i++) begin
      {arrival_time_alarm_flag, kinetic_temperature_alarm_flag,
       shelf_life_alarm_flag} <= (i < 4) ? fl[i] : ((i == 5) ? 3'h4 : 3'h0);
      battery_low <= (i > 3);
      press(4);
      tick(8);
      watch(16);
      if (i < 4) begin
        check("green_on", (i == 0) ? 16 : 0, g);
        check("red_on", (i == 0) ? 0 : 16, r);
      end else begin
        check("blink", 1'b1, (i == 4) ? (g > 0 && g < 16 && r == 0)
                                      : (r > 0 && r < 16 && g == 0));
      end
      tick(24);
    end
    {arrival_time_alarm_flag, kinetic_temperature_alarm_flag, shelf_life_alarm_flag} <= 3'h0;
    battery_low <= 1'b0;
  endtask

  task automatic t_no_enable;
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    long_hold(1'b1);
    check("op_state", 2'h0, op_state);
  endtask

  task automatic t_abandon;
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    long_hold(1'b0);
    check("op_state", 2'h0, op_state);
    check("leds", 2'h3, {led_green, led_red});
  endtask

  task automatic t_button_start;
    apb(1'b1, OFF_CMD, 32'h0000_0001);
    tick(4);
    check("op_state", 2'h1, op_state);
    tick(40);
    apb(1'b0, OFF_RTC, 32'h0000_0000);
    check("rtc_running", 1'b1, rd != 32'h0000_0000);
    press(12);
    tick(4);
    watch(12);
    check("green_fast", 1'b1, g > 0 && g < 12);
    press(4);
    check("op_state", 2'h2, op_state);
    tick(4);
    watch(40);
    check("green_slow", 1'b1, g > 0 && g < 40 && r == 0);
  endtask

  task automatic t_button_stop;
    apb(1'b1, OFF_CTRL, 32'h0000_0003);
    long_hold(1'b1);
    check("op_state", 2'h2, op_state);
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    press(12);
    tick(4);
    watch(12);
    check("red_fast", 1'b1, r > 0 && r < 12);
    press(4);
    check("op_state", 2'h3, op_state);
    tick(40);
    apb(1'b1, OFF_CMD, 32'h0000_0008);
    tick(4);
    check("op_state", 2'h0, op_state);
  endtask

  task automatic t_sampling;
    apb(1'b1, OFF_CTRL, 32'h0000_0004);
    apb(1'b1, OFF_BIN_EN, 32'h0000_0020);
    apb(1'b1, OFF_THR_BASE + 12'h014, 32'h0000_0001);
    apb(1'b1, OFF_INTERVAL, 32'h0000_0001);
    bin_in <= 4'h5;
    apb(1'b1, OFF_CMD, 32'h0000_0002);
    tick(4);
    check("op_state", 2'h2, op_state);
    for (int k = 0; k < 2; k++) begin
      int n;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (log_write !== 1'b1 && n < 200);
      check("log_write", 1'b1, log_write);
      check("log_addr", k, log_addr);
      slow <= 1'b1;
    end
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    check("bin_alarm", 1'b1, rd[STS_BIN]);
    apb(1'b1, OFF_CMD, 32'h0000_0004);
    tick(4);
    check("op_state", 2'h3, op_state);
    g = 0;
    repeat (64) begin
      @(posedge pclk);
      g += (sample_req === 1'b1);
    end
    check("sample_req", 0, g);
    apb(1'b0, OFF_SAMPLES, 32'h0000_0000);
    check("samples", 32'h0000_0002, rd);
    apb(1'b0, OFF_CNT_BASE + 12'h014, 32'h0000_0000);
    check("bin5_count", 32'h0000_0002, rd);
    apb(1'b1, OFF_CMD, 32'h0000_0008);
    tick(4);
    check("op_state", 2'h0, op_state);
    apb(1'b0, OFF_SAMPLES, 32'h0000_0000);
    check("samples", 32'h0000_0000, rd);
  endtask

  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0000_0000;
    button_pin = 1'b0;
    slow       = 1'b0;
    bin_in     = 4'h0;
    battery_low = 1'b0;
    arrival_time_alarm_flag        = 1'b0;
    kinetic_temperature_alarm_flag = 1'b0;
    shelf_life_alarm_flag          = 1'b0;
    tick(16);
    presetn <= 1'b1;
    tick(2);
    t_reset_state();
    t_status();
    t_no_enable();
    t_abandon();
    t_button_start();
    t_button_stop();
    t_sampling();
    test_done();
  end
endmodule

// File: verification/sensor_model.sv
`timescale 1ns/1ps
module sensor_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Request from the controller
  input  wire logic       sample_req,
  // Bench controls: answer delay and bin to report
  input  wire logic       slow,
  input  wire logic [3:0] bin_in,
  // Result back to the controller
  output logic            sample_valid,
  output logic      [3:0] sample_bin
);
  logic       pend;
  logic [2:0] cnt;
  logic [3:0] last;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend         <= 1'b0;
      cnt          <= 3'h0;
      last         <= 4'h0;
      sample_valid <= 1'b0;
      sample_bin   <= 4'h0;
    end else begin
      sample_valid <= 1'b0;
      // Bin bus is not held outside the result cycle
      sample_bin   <= ~last;
      if (sample_req) begin
        pend <= 1'b1;
        cnt  <= slow ? 3'h5 : 3'h1;
      end else if (pend) begin
        if (cnt == 3'h1) begin
          pend         <= 1'b0;
          sample_valid <= 1'b1;
          sample_bin   <= bin_in;
          last         <= bin_in;
        end else begin
          cnt <= cnt - 3'h1;
        end
      end
    end
  end
endmodule
